// ### core/clss_scan_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Start sampled on falling clock edge
// - 75 cycles pre-scan initialization after start
// - First sensor self-starts after 75 cycles
// - Later sensor waits for chain start pulse
// - End-of-scan pulse shortly before last pixel
// - Full mode end-of-scan at cycle 1442
// - Amplifier powered only while reading out
// - Straps select 2400/1200/600/300 dpi
// - 2400dpi: all 1376 pixels singly
// - 1200dpi: pixel pairs binned
// - 600dpi: groups of four binned
// - 300dpi: groups of eight binned
// - Readout time divided by the binning factor
// - Same clock for every resolution
// - New start aborts readout of stored pixels
module clss_scan_sequencer
  import clss_pkg::*;
#(
  parameter int unsigned PIXELS   = PIXEL_COUNT,
  parameter int unsigned PRESCAN  = PRESCAN_CYCLES,
  parameter int unsigned EOS_LEAD = EOS_LEAD_FULL
)(
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_global_scan_start,
  input  wire logic       i_chain_start,
  input  wire logic       i_first_in_chain_select,
  input  wire logic       i_resolution_select_a,
  input  wire logic       i_resolution_select_b,
  output logic            o_end_of_scan,
  output logic            o_amp_power,
  output logic            o_prescan_active,
  output clss_pix_t       o_pixel
);

  typedef enum logic [1:0] {S_IDLE, S_PRESCAN, S_WAIT, S_READ} clss_state_t;

  clss_state_t      state_reg;
  logic             gstart_neg_reg;
  logic             gstart_seen_reg;
  logic [CNT_W-1:0] pre_cnt_reg;
  logic [PIX_W-1:0] pix_reg;
  logic [PIX_W-1:0] pix_next;
  logic             eos_reg;
  logic             valid_reg;
  logic [PIX_W-1:0] first_reg;
  logic [3:0]       group_reg;
  logic             prescan_done;
  clss_bin_t        bin;
  logic [3:0]       group_size;
  logic             start_pulse;
  logic             last_group;
  logic             eos_hit;

  // ****************************************************************
  // Resolution decode
  // ****************************************************************
  clss_res_decode u_dec (
    .i_resolution_select_a (i_resolution_select_a),
    .i_resolution_select_b (i_resolution_select_b),
    .o_bin                 (bin),
    .o_group_size          (group_size)
  );

  // ****************************************************************
  // Start capture
  // ****************************************************************
  // Falling edge capture, then moved to the rising domain
  always_ff @(negedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gstart_neg_reg <= 1'b0;
    end else begin
      gstart_neg_reg <= i_global_scan_start;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gstart_seen_reg <= 1'b0;
    end else begin
      gstart_seen_reg <= gstart_neg_reg;
    end
  end

  // Rising edge of the sampled start; a held level starts only once
  assign start_pulse = gstart_neg_reg && !gstart_seen_reg;

  // ****************************************************************
  // Pixel pointer arithmetic
  // ****************************************************************
  function automatic logic [PIX_W-1:0] step(input logic [PIX_W-1:0] p,
                                             input logic [3:0] g);
    step = PIX_W'(p + PIX_W'(g));
  endfunction : step

  // Pixels not yet shifted out, seen from the pointer
  function automatic logic [PIX_W-1:0] remaining(input logic [PIX_W-1:0] p);
    remaining = PIX_W'(PIXELS) - p;
  endfunction : remaining

  assign pix_next   = step(pix_reg, group_size);
  assign last_group = remaining(pix_reg) <= PIX_W'(group_size);
  // End of scan lead fixed in output slots, so scaled up in pixels by binning so the hand-over
  // stays gapless at every resolution
  assign eos_hit    = remaining(pix_reg)
                      == PIX_W'((EOS_LEAD + 1) << bin);

  // ****************************************************************
  // Prescan counter
  // ****************************************************************
  // Counts only in the init phase; a new start clears it mid-line
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_cnt_reg <= '0;
    end else if (start_pulse) begin
      pre_cnt_reg <= '0;
    end else if (state_reg == S_PRESCAN) begin
      pre_cnt_reg <= CNT_W'(pre_cnt_reg + 1'b1);
    end
  end

  assign prescan_done = (pre_cnt_reg == CNT_W'(PRESCAN - 1));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= S_IDLE;
    end else if (start_pulse) begin
      state_reg <= S_PRESCAN;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          state_reg <= S_IDLE;
        end
        S_PRESCAN: begin
          if (prescan_done) begin
            if (i_first_in_chain_select) begin
              state_reg <= S_READ;
            end else begin
              state_reg <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (i_chain_start) begin
            state_reg <= S_READ;
          end
        end
        S_READ: begin
          if (last_group) begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Pixel pointer
  // ****************************************************************
  // Parked at zero outside readout so every line starts on pixel one
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pix_reg <= '0;
    end else if (start_pulse || (state_reg != S_READ)) begin
      pix_reg <= '0;
    end else begin
      pix_reg <= pix_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eos_reg <= 1'h0;
    end else begin
      eos_reg <= (state_reg == S_READ) && eos_hit;
    end
  end

  // A new start aborts readout: the pointer clears and prescan restarts
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      valid_reg <= 1'h0;
    end else begin
      valid_reg <= (state_reg == S_READ);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_reg <= '0;
    end else begin
      first_reg <= pix_reg;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      group_reg <= '0;
    end else begin
      group_reg <= group_size;
    end
  end

  assign o_end_of_scan    = eos_reg;
  assign o_amp_power      = valid_reg;
  assign o_prescan_active = (state_reg == S_PRESCAN);
  assign o_pixel          = '{valid: valid_reg, first_pixel: first_reg, group_size: group_reg};

endmodule : clss_scan_sequencer
`default_nettype wire

// ### core/clss_pkg.sv
// ****************************************************************
// Scan sequencer constants and types
// ****************************************************************
package clss_pkg;

  localparam int unsigned PIXEL_COUNT    = 1376;
  localparam int unsigned PRESCAN_CYCLES = 75;
  localparam int unsigned EOS_CYCLE_FULL = 1442;
  localparam int unsigned EOS_LEAD_FULL  = 9;
  localparam int unsigned PIX_W          = 11;
  localparam int unsigned CNT_W          = 12;

  localparam logic [1:0] RES_2400 = 2'h0;
  localparam logic [1:0] RES_1200 = 2'h1;
  localparam logic [1:0] RES_600  = 2'h2;
  localparam logic [1:0] RES_300  = 2'h3;

  typedef enum logic [1:0] {
    BIN_1 = 2'h0,
    BIN_2 = 2'h1,
    BIN_4 = 2'h2,
    BIN_8 = 2'h3
  } clss_bin_t;

  typedef struct packed {
    logic             valid;
    logic [PIX_W-1:0] first_pixel;
    logic [3:0]       group_size;
  } clss_pix_t;

endpackage : clss_pkg

// ### core/clss_res_decode.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Resolution strap decoder
// ****************************************************************
module clss_res_decode
  import clss_pkg::*;
(
  input  wire logic       i_resolution_select_a,
  input  wire logic       i_resolution_select_b,
  output clss_bin_t       o_bin,
  output logic [3:0]      o_group_size
);

  logic [1:0] sel;

  assign sel = {i_resolution_select_a, i_resolution_select_b};

  always_comb begin
    unique case (sel)
      RES_2400: o_bin = BIN_1;
      RES_1200: o_bin = BIN_2;
      RES_600:  o_bin = BIN_4;
      default:  o_bin = BIN_8;
    endcase
  end

  assign o_group_size = 4'(4'h1 << o_bin);

endmodule : clss_res_decode
`default_nettype wire

// ### sim/clss_scan_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Checker
// ****
module clss_scan_props
  import clss_pkg::*;
#(
  parameter int unsigned PIXELS   = PIXEL_COUNT,
  parameter int unsigned EOS_LEAD = EOS_LEAD_FULL
)(
  input wire logic      i_mclk,
  input wire logic      i_arst_n,
  input wire logic      i_chain_start,
  input wire logic      i_first_in_chain_select,
  input wire logic      i_resolution_select_a,
  input wire logic      i_resolution_select_b,
  input wire logic      o_end_of_scan,
  input wire logic      o_amp_power,
  input wire logic      o_prescan_active,
  input wire clss_pix_t o_pixel
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [3:0] g;
  assign g = 4'h1 << {i_resolution_select_a, i_resolution_select_b};
  property p_pre; $rose(o_prescan_active) |-> ##74 o_prescan_active ##1 !o_prescan_active;
  endproperty
  a_pre: assert property (p_pre) else $error("prescan length");
  property p_go; $fell(o_prescan_active) && i_first_in_chain_select |-> ##1 o_pixel.valid;
  endproperty
  a_go: assert property (p_go) else $error("no self start");
  property p_hold; $rose(o_pixel.valid) && !i_first_in_chain_select |->
    $past(i_chain_start) || $past(i_chain_start, 2); endproperty
  a_hold: assert property (p_hold) else $error("early readout");
  property p_amp; o_amp_power == o_pixel.valid; endproperty
  a_amp: assert property (p_amp) else $error("amp power");
  property p_size; o_pixel.valid |-> o_pixel.group_size == g; endproperty
  a_size: assert property (p_size) else $error("group size");
  property p_step; o_pixel.valid && $past(o_pixel.valid) |->
    o_pixel.first_pixel == $past(o_pixel.first_pixel) + 11'(g); endproperty
  a_step: assert property (p_step) else $error("pixel step");
  property p_eos; o_end_of_scan |-> o_pixel.valid &&
    o_pixel.first_pixel == 11'(PIXELS - (EOS_LEAD + 1) * g) ##1 !o_end_of_scan; endproperty
  a_eos: assert property (p_eos) else $error("eos place");
  property p_end; $fell(o_pixel.valid) |->
    $past(o_pixel.first_pixel) == 11'(PIXELS) - 11'($past(o_pixel.group_size)); endproperty
  a_end: assert property (p_end) else $error("line length");
endmodule : clss_scan_props
`default_nettype wire

// ### sim/clss_prev_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Preceding sensor
// ****
module clss_prev_model #(
  parameter int DLY = 150
)(
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_start,
  output logic      o_chain_start
);
  int cnt;
  // Same start as the device, own end-of-scan after its line
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 0;
      o_chain_start <= 1'h0;
    end else begin
      o_chain_start <= (cnt == 1);
      cnt <= i_start ? DLY : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule : clss_prev_model
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Bench
// ****
module testbench;
  import clss_pkg::*;
  logic      mclk, arst_n, start, chain, first, ra, rb, eos, amp, pre;
  clss_pix_t pix;
  int        fails = 0;
  int        n_compared = 0;
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  clss_prev_model #(.DLY(150)) i_clss_prev_model (.i_mclk(mclk), .i_arst_n(arst_n),
    .i_start(start), .o_chain_start(chain));
  // Short line keeps the run brief
  clss_scan_sequencer #(.PIXELS(128)) i_clss_scan_sequencer (.i_mclk(mclk),
    .i_arst_n(arst_n), .i_global_scan_start(start), .i_chain_start(chain),
    .i_first_in_chain_select(first), .i_resolution_select_a(ra),
    .i_resolution_select_b(rb), .o_end_of_scan(eos), .o_amp_power(amp),
    .o_prescan_active(pre), .o_pixel(pix));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic scan(input logic [1:0] m, input logic f);
    int   w;
    int   n;
    logic e;
    w = 0;
    n = 0;
    e = 1'h0;
    ra <= m[1];
    rb <= m[0];
    first <= f;
    start <= 1'h1;
    @(posedge mclk);
    start <= 1'h0;
    while (pix.valid !== 1'h1 && w < 400) begin
      @(negedge mclk);
      w++;
    end
    chk({15'h0, amp}, 16'h1);
    chk(16'(pix.first_pixel), 16'h0);
    chk(16'(pix.group_size), 16'(1 << m));
    while (pix.valid === 1'h1 && n < 200) begin
      e = e | eos;
      n++;
      @(negedge mclk);
    end
    chk(16'(n), 16'(128 >> m));
    chk({15'h0, e}, 16'h1);
    chk({15'h0, amp}, 16'h0);
    chk({15'h0, w >= (f ? 70 : 150)}, 16'h1);
    @(posedge mclk);
  endtask : scan
  initial begin
    {start, first, ra, rb} = 4'h0;
    arst_n = 1'h0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    for (int m = 0; m < 4; m++) scan(2'(m), 1'h1);
    scan(2'h3, 1'h0);
    results();
  end
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule : testbench
bind clss_scan_sequencer clss_scan_props #(.PIXELS(PIXELS), .EOS_LEAD(EOS_LEAD)) i_props (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_chain_start(i_chain_start),
  .i_first_in_chain_select(i_first_in_chain_select), .o_pixel(o_pixel),
  .i_resolution_select_a(i_resolution_select_a), .o_amp_power(o_amp_power),
  .i_resolution_select_b(i_resolution_select_b), .o_end_of_scan(o_end_of_scan),
  .o_prescan_active(o_prescan_active));
`default_nettype wire
